// >>> rtl/srcu_pkg.sv
package srcu_pkg;
   localparam int NUM_IN = 12;
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int OP_W = 8;
   localparam int FLG_W = 8;
   localparam int RDG_W = 24;
   localparam int SEL_W = 4;
   localparam int CFG_W = 10;
   localparam int NRELAY = 2;
   localparam logic [SEL_W-1:0] SEL_ALL = 4'h0;
   localparam logic [SEL_W-1:0] SEL_MAX = 4'hC;
   // Register byte offsets
   localparam logic [AW-1:0] A_OP_COND = 8'h00;
   localparam logic [AW-1:0] A_OP_MASK = 8'h04;
   localparam logic [AW-1:0] A_OP_LATCH = 8'h08;
   localparam logic [AW-1:0] A_OP_SUMMARY = 8'h0C;
   localparam logic [AW-1:0] A_RDG_SEL = 8'h10;
   localparam logic [AW-1:0] A_RDG_FLAGS = 8'h14;
   localparam logic [AW-1:0] A_RELAY1 = 8'h18;
   localparam logic [AW-1:0] A_RELAY2 = 8'h1C;
   localparam logic [AW-1:0] A_RELAY_STATE = 8'h20;
   localparam logic [AW-1:0] A_NET_STATUS = 8'h24;
   localparam logic [AW-1:0] A_NET_IP = 8'h28;
   localparam logic [AW-1:0] A_NET_DNS2 = 8'h38;
   localparam logic [AW-1:0] A_STR_PTR = 8'h3C;
   localparam logic [AW-1:0] A_STR_DATA = 8'h40;
   localparam logic [AW-1:0] A_SENSOR_UNITS_QUERY_SEL = 8'h44;
   localparam logic [AW-1:0] A_SENSOR_UNITS_QUERY_DATA = 8'h48;
   localparam int NUM_ADDR = 5;
   // Reset values and field layouts
   localparam logic [OP_W-1:0] OP_MASK_RST = 8'h00;
   localparam logic [FLG_W-1:0] FLG_MASK = 8'hF1;
   localparam int SENSOR_UNITS_QUERY_IDX_LSB = 24;
   localparam int SENSOR_UNITS_QUERY_LAST = 28;
   localparam int RLY_MODE_LSB = 0;
   localparam int RLY_IN_LSB = 4;
   localparam int RLY_TYPE_LSB = 8;
   localparam logic [CFG_W-1:0] RLY_CFG_RST = 10'h000;
   localparam logic [1:0] RLY_OFF = 2'h0;
   localparam logic [1:0] RLY_ON = 2'h1;
   localparam logic [1:0] RLY_ALARM = 2'h2;
   localparam logic [1:0] ALM_LOW = 2'h0;
   localparam logic [1:0] ALM_HIGH = 2'h1;
   localparam logic [1:0] ALM_BOTH = 2'h2;
   localparam int NET_W = 4;
   localparam logic [NET_W-1:0] NET_MAX = 4'h9;
   localparam logic [NET_W-1:0] NET_MOD_ERR = 4'h7;
   localparam logic [NET_W-1:0] NET_LINK_MAX = 4'h2;
   // String store
   localparam int NFIELD = 5;
   localparam int FLD_W = 3;
   localparam int IDX_W = 7;
   localparam int MEM_AW = 8;
   localparam int STR_FLD_LSB = 8;
   localparam int STR_CLR_BIT = 12;
   localparam logic [7:0] SPACE = 8'h20;
   localparam logic [IDX_W-1:0] LEN_HOST = 7'h0F;
   localparam logic [IDX_W-1:0] LEN_DOMAIN = 7'h40;
   localparam logic [IDX_W-1:0] LEN_DESC = 7'h20;
   localparam logic [IDX_W-1:0] LEN_USER = 7'h0F;
   localparam logic [IDX_W-1:0] LEN_PASS = 7'h0F;

   function automatic logic [IDX_W-1:0] str_limit(input logic [FLD_W-1:0] f);
      case (f)
         3'h0: str_limit = LEN_HOST;
         3'h1: str_limit = LEN_DOMAIN;
         3'h2: str_limit = LEN_DESC;
         3'h3: str_limit = LEN_USER;
         3'h4: str_limit = LEN_PASS;
         default: str_limit = 7'h00;
      endcase
   endfunction

   function automatic logic [MEM_AW-1:0] str_base(input logic [FLD_W-1:0] f);
      logic [MEM_AW-1:0] b;
      b = 8'h00;
      for (int i = 0; i < NFIELD; i++) begin
         if (FLD_W'(i) < f) begin
            b = b + MEM_AW'(str_limit(FLD_W'(i)));
         end
      end
      str_base = b;
   endfunction
endpackage

// >>> rtl/srcu_relay.sv
`timescale 1ns/1ps
`default_nettype none
module srcu_relay (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Configuration and alarms
   input wire logic [srcu_pkg::CFG_W-1:0] cfg_i,
   input wire logic [srcu_pkg::NUM_IN-1:0] alarm_lo_i,
   input wire logic [srcu_pkg::NUM_IN-1:0] alarm_hi_i,
   // Relay drive
   output logic relay_o
);
   logic [1:0] mode;
   logic [srcu_pkg::SEL_W-1:0] sel;
   logic [srcu_pkg::SEL_W-1:0] sel_idx;
   logic [1:0] atype;
   logic sel_ok;
   logic lo;
   logic hi;
   logic hit;
   logic nxt_relay;
   logic relay_ff;

   assign mode = cfg_i[srcu_pkg::RLY_MODE_LSB +: 2];
   assign sel = cfg_i[srcu_pkg::RLY_IN_LSB +: srcu_pkg::SEL_W];
   assign atype = cfg_i[srcu_pkg::RLY_TYPE_LSB +: 2];
   assign sel_idx = sel - 4'h1;
   assign sel_ok = (sel != srcu_pkg::SEL_ALL) && (sel <= srcu_pkg::SEL_MAX);
   assign lo = sel_ok && alarm_lo_i[sel_idx]; // [R7]
   assign hi = sel_ok && alarm_hi_i[sel_idx]; // [R7]
   assign hit = (atype == srcu_pkg::ALM_LOW) ? lo : // [R8]
      (atype == srcu_pkg::ALM_HIGH) ? hi :
      (atype == srcu_pkg::ALM_BOTH) ? (lo | hi) : 1'b0;
   assign nxt_relay = (mode == srcu_pkg::RLY_ON) ? 1'b1 : // [R6]
      (mode == srcu_pkg::RLY_ALARM) ? hit : 1'b0;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         relay_ff <= 1'b0;
      end else begin
         relay_ff <= nxt_relay;
      end
   end
   assign relay_o = relay_ff;

   a_relay_forced: assert property ( // [R6]
      @(posedge clk_i) disable iff (!rstn_i)
      (mode == srcu_pkg::RLY_OFF || mode == srcu_pkg::RLY_ON)
      |=> relay_o == ($past(mode) == srcu_pkg::RLY_ON))
      else $error("Relay does not follow forced mode");
   a_relay_low_alarm: assert property ( // [R8]
      @(posedge clk_i) disable iff (!rstn_i)
      (mode == srcu_pkg::RLY_ALARM && atype == srcu_pkg::ALM_LOW)
      |=> relay_o == $past(lo))
      else $error("Relay does not follow low alarm");
   a_relay_no_alarm: assert property ( // [R7]
      @(posedge clk_i) disable iff (!rstn_i)
      (mode == srcu_pkg::RLY_ALARM && !lo && !hi) |=> !relay_o)
      else $error("Relay on without selected alarm");
endmodule
`default_nettype wire

// >>> rtl/srcu_str_mem.sv
`timescale 1ns/1ps
`default_nettype none
module srcu_str_mem (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Character access
   input wire logic [srcu_pkg::FLD_W-1:0] field_i,
   input wire logic [srcu_pkg::IDX_W-1:0] idx_i,
   input wire logic we_i,
   input wire logic re_i,
   input wire logic clr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   localparam int MAW = srcu_pkg::MEM_AW;
   logic [7:0] mem_ff [2**MAW];
   logic [srcu_pkg::IDX_W-1:0] len_ff [srcu_pkg::NFIELD];
   logic [srcu_pkg::IDX_W-1:0] limit;
   logic [srcu_pkg::IDX_W-1:0] cur_len;
   logic [MAW-1:0] addr;
   logic fld_ok;
   logic in_range;
   logic [7:0] nxt_rdata;
   logic [7:0] rdata_ff;

   assign limit = srcu_pkg::str_limit(field_i);
   assign fld_ok = 32'(field_i) < srcu_pkg::NFIELD;
   assign cur_len = fld_ok ? len_ff[field_i] : 7'h00;
   assign in_range = idx_i < limit; // [R11] [R12]
   assign addr = srcu_pkg::str_base(field_i) + MAW'(idx_i);
   assign nxt_rdata = !in_range ? 8'h00 :
      (idx_i < cur_len) ? mem_ff[addr] : srcu_pkg::SPACE; // [R14]

   always_ff @(posedge clk_i) begin
      if (we_i && in_range) begin
         mem_ff[addr] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < srcu_pkg::NFIELD; i++) begin
            len_ff[i] <= 7'h00;
         end
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= re_i ? nxt_rdata : 8'h00;
         if (clr_i && fld_ok) begin
            len_ff[field_i] <= 7'h00;
         end else if (we_i && in_range && idx_i >= cur_len) begin
            len_ff[field_i] <= idx_i + 7'h01;
         end
      end
   end
   assign rdata_o = rdata_ff;

   a_pad_space: assert property ( // [R14]
      @(posedge clk_i) disable iff (!rstn_i)
      (re_i && in_range && idx_i >= cur_len) |=> rdata_o == srcu_pkg::SPACE)
      else $error("Unwritten character not padded with space");
   a_len_limit: assert property ( // [R11]
      @(posedge clk_i) disable iff (!rstn_i)
      fld_ok |-> cur_len <= limit)
      else $error("String length above field limit");
endmodule
`default_nettype wire

// >>> rtl/srcu_top.sv
// Overview of operation
// R1: Status bits latch on detection; reading the latch register clears it.
// R2: Enable mask selects which latched bits raise the summary bit.
// R3: Reading status is a weighted flag sum; zero means valid reading.
// R4: Flags: bit0 invalid, 4 under, 5 over, 6 units zero, 7 units over.
// R5: Host addresses only relay one or two.
// R6: Relay mode 0 off, 1 on, 2 alarm driven.
// R7: In alarm mode the relay follows one chosen input of twelve.
// R8: Alarm type 0 low, 1 high, 2 either alarm.
// R9: Network status reports codes 0 through 9.
// R10: Unconfigured network returns all address fields as zero.
// R11: Host name 15, domain 64, description 32 characters at most.
// R12: Web username and password hold up to 15 characters each.
// R13: Host quotes strings holding spaces, commas or semicolons.
// R14: Returned strings are padded with spaces to full field length.
// R15: Reading query with selector zero returns all inputs in turn.
// R16: Host picks curve 1, 6 or 7, destination 21-59, short serial.
// R17: A condition seen during clear-on-read stays latched.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module srcu_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Register port
   input wire logic [srcu_pkg::AW-1:0] addr_i,
   input wire logic [srcu_pkg::DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [srcu_pkg::DW-1:0] rdata_o,
   // Operational status
   input wire logic [srcu_pkg::OP_W-1:0] op_cond_i,
   output logic op_summary_o,
   // Input readings
   input wire logic [srcu_pkg::NUM_IN*srcu_pkg::FLG_W-1:0] rdg_flags_i,
   input wire logic [srcu_pkg::NUM_IN*srcu_pkg::RDG_W-1:0] sensor_rdg_i,
   // Alarms and relays
   input wire logic [srcu_pkg::NUM_IN-1:0] alarm_lo_i,
   input wire logic [srcu_pkg::NUM_IN-1:0] alarm_hi_i,
   output logic [srcu_pkg::NRELAY-1:0] relay_o,
   // Network
   input wire logic [srcu_pkg::NET_W-1:0] net_status_i
);
   localparam int DW = srcu_pkg::DW;
   localparam int SW = srcu_pkg::SEL_W;
   localparam int IW = srcu_pkg::IDX_W;

   logic [srcu_pkg::OP_W-1:0] op_mask_ff;
   logic [srcu_pkg::OP_W-1:0] op_latch_ff;
   logic [srcu_pkg::OP_W-1:0] nxt_op_latch;
   logic summary_ff;
   logic [SW-1:0] rdg_sel_ff;
   logic [SW-1:0] sensor_units_query_sel_ff;
   logic [SW-1:0] walk_ff;
   logic [SW-1:0] nxt_walk;
   logic [srcu_pkg::CFG_W-1:0] relay_cfg_ff [srcu_pkg::NRELAY];
   logic [DW-1:0] net_addr_ff [srcu_pkg::NUM_ADDR];
   logic [srcu_pkg::FLD_W-1:0] str_fld_ff;
   logic [IW-1:0] str_idx_ff;
   logic [IW-1:0] nxt_str_idx;
   logic str_rd_ff;
   logic [DW-1:0] rdata_ff;
   logic [DW-1:0] nxt_rdata;

   // Address decode
   logic wr_mask;
   logic rd_latch;
   logic wr_rdg_sel;
   logic wr_sensor_units_query_sel;
   logic rd_sensor_units_query;
   logic wr_ptr;
   logic wr_str;
   logic rd_str;
   logic str_acc;
   logic net_hit;
   logic [2:0] net_slot;

   assign wr_mask = wr_i && (addr_i == srcu_pkg::A_OP_MASK);
   assign rd_latch = rd_i && (addr_i == srcu_pkg::A_OP_LATCH);
   assign wr_rdg_sel = wr_i && (addr_i == srcu_pkg::A_RDG_SEL);
   assign wr_sensor_units_query_sel = wr_i && (addr_i == srcu_pkg::A_SENSOR_UNITS_QUERY_SEL);
   assign rd_sensor_units_query = rd_i && (addr_i == srcu_pkg::A_SENSOR_UNITS_QUERY_DATA);
   assign wr_ptr = wr_i && (addr_i == srcu_pkg::A_STR_PTR);
   assign wr_str = wr_i && (addr_i == srcu_pkg::A_STR_DATA);
   assign rd_str = rd_i && (addr_i == srcu_pkg::A_STR_DATA);
   assign str_acc = wr_str || rd_str;
   assign net_hit = (addr_i >= srcu_pkg::A_NET_IP) &&
      (addr_i <= srcu_pkg::A_NET_DNS2);
   assign net_slot = 3'((addr_i - srcu_pkg::A_NET_IP) >> 2);

   // Operational status latch and summary
   assign nxt_op_latch = (rd_latch ? '0 : op_latch_ff) | // [R1] [R17]
      op_cond_i;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         op_mask_ff <= srcu_pkg::OP_MASK_RST;
         op_latch_ff <= '0;
         summary_ff <= 1'b0;
      end else begin
         if (wr_mask) begin
            op_mask_ff <= wdata_i[srcu_pkg::OP_W-1:0]; // [R2]
         end
         op_latch_ff <= nxt_op_latch;
         summary_ff <= |(op_latch_ff & op_mask_ff); // [R2]
      end
   end
   assign op_summary_o = summary_ff;

   // Reading flags of one input
   logic [SW-1:0] rdg_idx;
   logic rdg_ok;
   logic [srcu_pkg::FLG_W-1:0] rdg_flags;
   assign rdg_idx = rdg_sel_ff - 4'h1;
   assign rdg_ok = (rdg_sel_ff != srcu_pkg::SEL_ALL) &&
      (rdg_sel_ff <= srcu_pkg::SEL_MAX);
   assign rdg_flags = rdg_ok ?
      (rdg_flags_i[rdg_idx*srcu_pkg::FLG_W +: srcu_pkg::FLG_W] &
      srcu_pkg::FLG_MASK) : '0; // [R3] [R4]

   // Sensor reading, single input or walk over all
   logic [SW-1:0] sensor_units_query_cur;
   logic [SW-1:0] sensor_units_query_idx;
   logic sensor_units_query_ok;
   logic sensor_units_query_last;
   logic [srcu_pkg::RDG_W-1:0] sensor_units_query_val;
   assign sensor_units_query_cur = (sensor_units_query_sel_ff == srcu_pkg::SEL_ALL) ?
      walk_ff : sensor_units_query_sel_ff; // [R15]
   assign sensor_units_query_idx = sensor_units_query_cur - 4'h1;
   assign sensor_units_query_ok = (sensor_units_query_cur != srcu_pkg::SEL_ALL) &&
      (sensor_units_query_cur <= srcu_pkg::SEL_MAX);
   assign sensor_units_query_val = sensor_units_query_ok ?
      sensor_rdg_i[sensor_units_query_idx*srcu_pkg::RDG_W +: srcu_pkg::RDG_W] : '0;
   assign sensor_units_query_last = (sensor_units_query_sel_ff != srcu_pkg::SEL_ALL) ||
      (walk_ff == srcu_pkg::SEL_MAX);
   assign nxt_walk = wr_sensor_units_query_sel ? 4'h1 :
      (rd_sensor_units_query && sensor_units_query_sel_ff == srcu_pkg::SEL_ALL) ?
      (sensor_units_query_last ? 4'h1 : walk_ff + 4'h1) : walk_ff; // [R15]

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdg_sel_ff <= srcu_pkg::SEL_ALL;
         sensor_units_query_sel_ff <= srcu_pkg::SEL_ALL;
         walk_ff <= 4'h1;
      end else begin
         if (wr_rdg_sel) begin
            rdg_sel_ff <= wdata_i[SW-1:0];
         end
         if (wr_sensor_units_query_sel) begin
            sensor_units_query_sel_ff <= wdata_i[SW-1:0];
         end
         walk_ff <= nxt_walk;
      end
   end

   // Relays
   for (genvar g = 0; g < srcu_pkg::NRELAY; g++) begin : g_relay
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            relay_cfg_ff[g] <= srcu_pkg::RLY_CFG_RST;
         end else if (wr_i && addr_i == srcu_pkg::A_RELAY1 +
            srcu_pkg::AW'(4 * g)) begin
            relay_cfg_ff[g] <= wdata_i[srcu_pkg::CFG_W-1:0]; // [R5]
         end
      end
      srcu_relay i_srcu_relay (
         .clk_i(clk_i),
         .rstn_i(rstn_i),
         .cfg_i(relay_cfg_ff[g]),
         .alarm_lo_i(alarm_lo_i),
         .alarm_hi_i(alarm_hi_i),
         .relay_o(relay_o[g])
      );
   end

   // Network status and stored addresses
   logic [srcu_pkg::NET_W-1:0] net_code;
   logic net_cfg_ok;
   assign net_code = (net_status_i > srcu_pkg::NET_MAX) ?
      srcu_pkg::NET_MOD_ERR : net_status_i; // [R9]
   assign net_cfg_ok = net_status_i <= srcu_pkg::NET_LINK_MAX;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < srcu_pkg::NUM_ADDR; i++) begin
            net_addr_ff[i] <= '0;
         end
      end else if (wr_i && net_hit) begin
         net_addr_ff[net_slot] <= wdata_i;
      end
   end

   // String pointer
   logic [srcu_pkg::FLD_W-1:0] mem_fld;
   logic [IW-1:0] str_lim;
   logic [7:0] str_rdata;
   assign mem_fld = wr_ptr ?
      wdata_i[srcu_pkg::STR_FLD_LSB +: srcu_pkg::FLD_W] : str_fld_ff;
   assign str_lim = srcu_pkg::str_limit(str_fld_ff);
   assign nxt_str_idx = wr_ptr ? wdata_i[IW-1:0] :
      (str_acc && str_idx_ff < str_lim) ?
      str_idx_ff + 7'h01 : str_idx_ff; // [R11] [R12]

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         str_fld_ff <= '0;
         str_idx_ff <= '0;
      end else begin
         str_fld_ff <= mem_fld;
         str_idx_ff <= nxt_str_idx;
      end
   end

   srcu_str_mem i_srcu_str_mem (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .field_i(mem_fld),
      .idx_i(str_idx_ff),
      .we_i(wr_str),
      .re_i(rd_str),
      .clr_i(wr_ptr && wdata_i[srcu_pkg::STR_CLR_BIT]),
      .wdata_i(wdata_i[7:0]),
      .rdata_o(str_rdata)
   );

   // Read data, one cycle after the strobe
   assign nxt_rdata =
      (addr_i == srcu_pkg::A_OP_COND) ? DW'(op_cond_i) :
      (addr_i == srcu_pkg::A_OP_MASK) ? DW'(op_mask_ff) :
      (addr_i == srcu_pkg::A_OP_LATCH) ? DW'(op_latch_ff) :
      (addr_i == srcu_pkg::A_OP_SUMMARY) ? DW'(summary_ff) :
      (addr_i == srcu_pkg::A_RDG_SEL) ? DW'(rdg_sel_ff) :
      (addr_i == srcu_pkg::A_RDG_FLAGS) ? DW'(rdg_flags) :
      (addr_i == srcu_pkg::A_RELAY1) ? DW'(relay_cfg_ff[0]) :
      (addr_i == srcu_pkg::A_RELAY2) ? DW'(relay_cfg_ff[1]) :
      (addr_i == srcu_pkg::A_RELAY_STATE) ? DW'(relay_o) :
      (addr_i == srcu_pkg::A_NET_STATUS) ? DW'(net_code) :
      (net_hit && net_cfg_ok) ? net_addr_ff[net_slot] : // [R10]
      (addr_i == srcu_pkg::A_STR_PTR) ?
      DW'({str_fld_ff, 1'b0, str_idx_ff}) :
      (addr_i == srcu_pkg::A_SENSOR_UNITS_QUERY_SEL) ? DW'(sensor_units_query_sel_ff) :
      (addr_i == srcu_pkg::A_SENSOR_UNITS_QUERY_DATA) ?
      DW'({sensor_units_query_last, sensor_units_query_cur, sensor_units_query_val}) : '0;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_ff <= '0;
         str_rd_ff <= 1'b0;
      end else begin
         rdata_ff <= (rd_i && !rd_str) ? nxt_rdata : '0;
         str_rd_ff <= rd_str;
      end
   end
   assign rdata_o = str_rd_ff ? DW'(str_rdata) : rdata_ff; // [R14]

   // Checks
   a_latch_sticky: assert property ( // [R17]
      @(posedge clk_i) disable iff (!rstn_i)
      (op_cond_i != '0) |=> ((op_latch_ff & $past(op_cond_i)) ==
      $past(op_cond_i)))
      else $error("Detected condition not latched");
   a_latch_clear: assert property ( // [R1]
      @(posedge clk_i) disable iff (!rstn_i)
      (rd_latch && op_cond_i == '0) |=> op_latch_ff == '0
      ##1 (!$past(rd_latch) || rdata_o == '0))
      else $error("Latched status not cleared by read");
   a_latch_read: assert property ( // [R1]
      @(posedge clk_i) disable iff (!rstn_i)
      rd_latch |=> rdata_o == DW'($past(op_latch_ff)))
      else $error("Latched status read value wrong");
   a_summary_mask: assert property ( // [R2]
      @(posedge clk_i) disable iff (!rstn_i)
      ((op_latch_ff & op_mask_ff) == '0) |=> !op_summary_o)
      else $error("Summary set by masked bit");
   a_summary_set: assert property ( // [R2]
      @(posedge clk_i) disable iff (!rstn_i)
      ((op_latch_ff & op_mask_ff) != '0) |=> op_summary_o)
      else $error("Enabled bit did not set summary");
   a_flags_layout: assert property ( // [R4]
      @(posedge clk_i) disable iff (!rstn_i)
      (rd_i && addr_i == srcu_pkg::A_RDG_FLAGS)
      |=> (rdata_o & ~DW'(srcu_pkg::FLG_MASK)) == '0)
      else $error("Reserved reading flag bits set");
   a_flags_valid: assert property ( // [R3]
      @(posedge clk_i) disable iff (!rstn_i)
      (rd_i && addr_i == srcu_pkg::A_RDG_FLAGS && rdg_ok &&
      rdg_flags_i[rdg_idx*srcu_pkg::FLG_W +: srcu_pkg::FLG_W] == '0)
      |=> rdata_o == '0)
      else $error("Valid reading not reported as zero");
   a_net_code: assert property ( // [R9]
      @(posedge clk_i) disable iff (!rstn_i)
      (rd_i && addr_i == srcu_pkg::A_NET_STATUS)
      |=> rdata_o <= DW'(srcu_pkg::NET_MAX))
      else $error("Network status code out of range");
   a_net_zero: assert property ( // [R10]
      @(posedge clk_i) disable iff (!rstn_i)
      (rd_i && net_hit && !net_cfg_ok) |=> rdata_o == '0)
      else $error("Unconfigured network address not zero");
   a_sensor_units_query_walk: assert property ( // [R15]
      @(posedge clk_i) disable iff (!rstn_i)
      (rd_sensor_units_query && sensor_units_query_sel_ff == srcu_pkg::SEL_ALL && !sensor_units_query_last &&
      !wr_i) |=> walk_ff == $past(walk_ff) + 4'h1)
      else $error("All-inputs reply did not advance");
   a_str_bound: assert property ( // [R11]
      @(posedge clk_i) disable iff (!rstn_i)
      (str_acc && !wr_ptr) |=> str_idx_ff <= srcu_pkg::str_limit(str_fld_ff))
      else $error("String index past field limit");
endmodule
`default_nettype wire

// >>> verif/srcu_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module srcu_front_model (
   // Reading sources for the twelve inputs
   output logic [95:0] rdg_flags_o,
   output logic [287:0] sensor_rdg_o
);
   // Distinct flags and readings per input; input one reads valid
   for (genvar k = 0; k < 12; k++) begin : g_in
      assign rdg_flags_o[k*8 +: 8] = 8'(k * 8'h13);
      assign sensor_rdg_o[k*24 +: 24] = 24'h10_0000 | 24'(k + 1);
   end
endmodule
`default_nettype wire

// >>> verif/srcu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module srcu_top_tb;
   logic clk_i, rstn_i, wr_i, rd_i, op_summary_o, e;
   logic [7:0] addr_i, op_cond_i, ch;
   logic [31:0] wdata_i, rdata_o, d;
   logic [95:0] rdg_flags_i;
   logic [287:0] sensor_rdg_i;
   logic [11:0] alarm_lo_i, alarm_hi_i;
   logic [1:0] relay_o;
   logic [3:0] net_status_i;
   logic [6:0] lim, n;
   logic [6:0] lims [5] = '{srcu_pkg::LEN_HOST, srcu_pkg::LEN_DOMAIN,
      srcu_pkg::LEN_DESC, srcu_pkg::LEN_USER, srcu_pkg::LEN_PASS};
   int mismatches, checked, k;

   srcu_top i_srcu_top (
      .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .op_cond_i(op_cond_i),
      .op_summary_o(op_summary_o), .rdg_flags_i(rdg_flags_i),
      .sensor_rdg_i(sensor_rdg_i), .alarm_lo_i(alarm_lo_i),
      .alarm_hi_i(alarm_hi_i), .relay_o(relay_o),
      .net_status_i(net_status_i));
   srcu_front_model i_srcu_front_model (
      .rdg_flags_o(rdg_flags_i), .sensor_rdg_o(sensor_rdg_i));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task automatic end_sim();
      if (mismatches == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int c);
      repeat (c) @(posedge clk_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk(v, exp);
   endtask

   // Hang guard
   initial begin
      repeat (50000) @(posedge clk_i);
      mismatches++;
      end_sim();
   end

   initial begin
      rstn_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 32'h0000_0000;
      op_cond_i = 8'h00;
      alarm_lo_i = 12'h000;
      alarm_hi_i = 12'h000;
      net_status_i = 4'h0;
      repeat (8) @(posedge clk_i);
      rstn_i <= 1'b1;
      rc(srcu_pkg::A_OP_MASK, 32'h0000_0000);
      rc(srcu_pkg::A_RELAY1, 32'h0000_0000);
      wr(8'hFC, 32'hFFFF_FFFF);
      rc(8'hFC, 32'h0000_0000);
      chk(32'(relay_o), 32'h0000_0000);
      // Pulse latches, then clear on read
      @(posedge clk_i);
      op_cond_i <= 8'h05;
      @(posedge clk_i);
      op_cond_i <= 8'h00;
      cyc(2);
      rc(srcu_pkg::A_OP_LATCH, 32'h0000_0005);
      rc(srcu_pkg::A_OP_LATCH, 32'h0000_0000);
      @(posedge clk_i);
      op_cond_i <= 8'h80;
      wr(srcu_pkg::A_OP_MASK, 32'h0000_0001);
      cyc(3);
      chk(32'(op_summary_o), 32'h0000_0000);
      rc(srcu_pkg::A_OP_SUMMARY, 32'h0000_0000);
      wr(srcu_pkg::A_OP_MASK, 32'h0000_0080);
      cyc(3);
      chk(32'(op_summary_o), 32'h0000_0001);
      rc(srcu_pkg::A_OP_SUMMARY, 32'h0000_0001);
      rc(srcu_pkg::A_OP_MASK, 32'h0000_0080);
      rc(srcu_pkg::A_OP_COND, 32'h0000_0080);
      // Held condition survives each clear
      rc(srcu_pkg::A_OP_LATCH, 32'h0000_0080);
      rc(srcu_pkg::A_OP_LATCH, 32'h0000_0080);
      @(posedge clk_i);
      op_cond_i <= 8'h00;
      cyc(2);
      rc(srcu_pkg::A_OP_LATCH, 32'h0000_0080);
      rc(srcu_pkg::A_OP_LATCH, 32'h0000_0000);
      cyc(2);
      chk(32'(op_summary_o), 32'h0000_0000);
      // Flags per input, out-of-range selectors read zero
      for (int i = 0; i <= 13; i++) begin
         wr(srcu_pkg::A_RDG_SEL, 32'(i));
         e = i >= 1 && i <= 12;
         d = e ? 32'(8'((i - 1) * 8'h13) & 8'hF1) : 32'h0000_0000;
         rc(srcu_pkg::A_RDG_FLAGS, d);
      end
      // Every relay, mode, alarm type and alarm pattern on input three
      for (int r = 0; r < 2; r++) begin
         for (int m = 0; m < 3; m++) begin
            for (int t = 0; t < 3; t++) begin
               for (int p = 0; p < 4; p++) begin
                  @(posedge clk_i);
                  alarm_lo_i <= (p % 2 == 1) ? 12'h004 : 12'hFFB;
                  alarm_hi_i <= (p / 2 == 1) ? 12'h004 : 12'hFFB;
                  wr(r == 0 ? srcu_pkg::A_RELAY1 : srcu_pkg::A_RELAY2,
                     {22'h00_0000, 2'(t), 4'h3, 2'h0, 2'(m)});
                  cyc(2);
                  e = (m == 1) || (m == 2 && ((t != 1 && p % 2 == 1) ||
                     (t != 0 && p / 2 == 1)));
                  chk(32'(relay_o[r]), 32'(e));
                  rd(srcu_pkg::A_RELAY_STATE, d);
                  chk(32'(d[r]), 32'(e));
               end
            end
         end
      end
      // Status codes and address fields gated by configuration
      wr(srcu_pkg::A_NET_IP, 32'hC0A8_0001);
      wr(srcu_pkg::A_NET_DNS2, 32'h0A00_0002);
      for (int c = 0; c < 16; c++) begin
         @(posedge clk_i);
         net_status_i <= 4'(c);
         cyc(2);
         rc(srcu_pkg::A_NET_STATUS, (c > 9) ? 32'h7 : 32'(c));
         d = (c <= 2) ? 32'hC0A8_0001 : 32'h0000_0000;
         rc(srcu_pkg::A_NET_IP, d);
         d = (c <= 2) ? 32'h0A00_0002 : 32'h0000_0000;
         rc(srcu_pkg::A_NET_DNS2, d);
      end
      // Strings: overlong writes dropped, short ones padded
      for (int f = 0; f < 5; f++) begin
         lim = lims[f];
         n = (f % 2 == 0) ? lim + 7'h01 : 7'h03;
         wr(srcu_pkg::A_STR_PTR, {19'h0_0000, 1'b1, 1'b0, 3'(f), 8'h00});
         for (int i = 0; i < n; i++) begin
            wr(srcu_pkg::A_STR_DATA, 32'h0000_0041 + 32'(i));
         end
         wr(srcu_pkg::A_STR_PTR, {21'h00_0000, 3'(f), 8'h00});
         for (int i = 0; i <= lim + 1; i++) begin
            ch = (i < lim) ? 8'h20 : 8'h00;
            ch = (i < n && i < lim) ? 8'h41 + 8'(i) : ch;
            rc(srcu_pkg::A_STR_DATA, 32'(ch));
         end
      end
      // Reading walk over all inputs, then a single input
      wr(srcu_pkg::A_SENSOR_UNITS_QUERY_SEL, 32'h0000_0000);
      for (int i = 0; i < 13; i++) begin
         k = i % 12 + 1;
         d = {3'h0, k == 12, 4'(k), 24'h10_0000 | 24'(k)};
         rc(srcu_pkg::A_SENSOR_UNITS_QUERY_DATA, d);
      end
      wr(srcu_pkg::A_SENSOR_UNITS_QUERY_SEL, 32'h0000_0005);
      rc(srcu_pkg::A_SENSOR_UNITS_QUERY_DATA, 32'h1510_0005);
      end_sim();
   end
endmodule
`default_nettype wire
